// ### hdl/pst_defines.vh
// constants for the protection status register block
`ifndef PST_DEFINES_VH
`define PST_DEFINES_VH
`define PST_ADDR_STATUS 8'hc4
`define PST_ADDR_CONTROL 8'hc3
`define PST_STATUS_RESET 8'h00
`define PST_BIT_LINK_ERR 7
`define PST_BIT_REMOTE_IRQ 6
`define PST_BIT_LOCK 5
`define PST_BIT_HOT_PLUG 4
`define PST_BIT_PRESENT 3
`define PST_BIT_LIST_RDY 2
`define PST_BIT_KEY_RDY 1
`define PST_BIT_AUTHENTICATED_FLAG 0
`define PST_CTL_RESTART 0
`define PST_CTL_KEY_OK 4
`define PST_CTL_LIST_OK 5
`endif

// ### hdl/pst_sync2.v
// two-flop synchroniser for a group of level inputs
`timescale 1ns/1ns
module pst_sync2 #(
  parameter W = 4
) (
  input wire clk, // system clock
  input wire rst, // synchronous reset, active high
  input wire [W-1:0] d, // asynchronous levels
  output reg [W-1:0] q_ff // synchronised levels
);
  reg [W-1:0] meta_ff;
  always @(posedge clk) begin
    if (rst) begin
      meta_ff <= {W{1'b0}};
      q_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
endmodule

// ### hdl/pst_status_reg.v
// protection status register with read-clear and approval-clear flags
`timescale 1ns/1ns
`include "pst_defines.vh"
//
// Behaviour
// R1: set bit 7 when an embedded channel error is detected.
// R2: bit 7 clears when the host reads the status register.
// R3: bit 6 mirrors the active-low remote interrupt input; 0 means pending.
// R4: bit 5 set while the downstream receiver reports lock.
// R5: bit 4 set on a hot-plug event from local device or repeater.
// R6: bit 4 clears when the host reads the status register.
// R7: bit 3 set while a downstream receiver is detected.
// R8: bit 2 set once the key list is loaded into the list buffer.
// R9: after key-list ready, authentication stalls until host approves the list.
// R10: bit 2 clears when the host sets the key-list approval bit.
// R11: bit 1 set once the receiver key is stored in key registers.
// R12: non-repeater pauses after key-ready until host approves the receiver key.
// R13: bit 1 clears on receiver-key approval or authentication failure.
// R14: bit 0 set when authentication completes successfully.
// R15: host sends protected content only after bit 0 shows authenticated.
// R16: bit 0 clears when authentication is lost or host restarts it.
// R17: host approves key list after revocation check; approval self-clears.
// R18: host approves receiver key after revocation check; writing 0 does nothing.
// R19: status writes are ignored; all bits read zero after reset.
module pst_status_reg (
  input wire clk, // 10 MHz system clock
  input wire rst, // synchronous reset, active high
  input wire [7:0] reg_addr, // register address from control bus
  input wire reg_wr, // one-cycle write strobe
  input wire [7:0] reg_wdata, // write data
  input wire reg_rd, // one-cycle read strobe
  output reg [7:0] reg_rdata_ff, // read data, valid cycle after reg_rd
  input wire link_error_evt, // embedded channel error pulse
  input wire hot_plug_evt, // hot-plug event pulse
  input wire key_list_loaded_evt, // key list placed in buffer, pulse
  input wire receiver_key_loaded_evt, // receiver key stored, pulse
  input wire auth_pass_evt, // authentication success pulse
  input wire auth_fail_evt, // authentication failure or loss pulse
  input wire repeater_mode, // device acts as repeater (same clock)
  input wire remote_irq_input, // remote interrupt pin, active low, async
  input wire remote_lock_pin, // remote lock indication, async
  input wire receiver_present_pin, // receiver detected, async
  output reg auth_stall_ff, // hold authentication engine while high
  output reg restart_auth_ff, // one-cycle restart pulse to engine
  output reg [7:0] protection_status_ff // live status for other logic
);
  wire [2:0] sync_q;
  wire ctl_wr;
  wire sts_rd;
  wire list_ok;
  wire key_ok;
  wire restart;
  wire irq_level;
  wire lock_level;
  wire present_level;
  reg link_error_flag_ff;
  reg hot_plug_flag_ff;
  reg key_list_ready_ff;
  reg receiver_key_ready_ff;
  reg authenticated_flag_ff;
  reg nxt_link_error_flag;
  reg nxt_hot_plug_flag;
  reg nxt_key_list_ready;
  reg nxt_receiver_key_ready;
  reg nxt_authenticated_flag;
  reg nxt_auth_stall;
  reg nxt_restart_auth;
  reg [7:0] nxt_reg_rdata;
  reg [7:0] nxt_status;

  // set wins over clear so no event is lost in the clearing cycle
  function pst_flag_next(input set_evt, input clr_evt, input cur);
    if (set_evt)
      pst_flag_next = 1'b1;
    else if (clr_evt)
      pst_flag_next = 1'b0;
    else
      pst_flag_next = cur;
  endfunction

  // strobe qualified by a full byte address match, so no aliases exist
  function pst_hit(input strobe, input [7:0] addr, input [7:0] target);
    pst_hit = strobe && (addr == target);
  endfunction

  // pins from the remote side are async: two flops before use
  pst_sync2 #(.W(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({remote_irq_input, remote_lock_pin, receiver_present_pin}),
    .q_ff(sync_q)
  );

  assign irq_level = sync_q[2]; // see R3
  assign lock_level = sync_q[1]; // see R4
  assign present_level = sync_q[0]; // see R7

  assign ctl_wr = pst_hit(reg_wr, reg_addr, `PST_ADDR_CONTROL);
  assign sts_rd = pst_hit(reg_rd, reg_addr, `PST_ADDR_STATUS);

  // approval bits act only on a written 1; a written 0 has no effect
  assign list_ok = ctl_wr && reg_wdata[`PST_CTL_LIST_OK]; // see R10
  assign key_ok = ctl_wr && reg_wdata[`PST_CTL_KEY_OK]; // see R13
  assign restart = ctl_wr && reg_wdata[`PST_CTL_RESTART]; // see R16

  // status byte as the host sees it, before this edge's clears act
  always @* begin
    nxt_status = `PST_STATUS_RESET;
    nxt_status[`PST_BIT_LINK_ERR] = link_error_flag_ff;
    nxt_status[`PST_BIT_REMOTE_IRQ] = irq_level; // see R3
    nxt_status[`PST_BIT_LOCK] = lock_level; // see R4
    nxt_status[`PST_BIT_HOT_PLUG] = hot_plug_flag_ff;
    nxt_status[`PST_BIT_PRESENT] = present_level; // see R7
    nxt_status[`PST_BIT_LIST_RDY] = key_list_ready_ff;
    nxt_status[`PST_BIT_KEY_RDY] = receiver_key_ready_ff;
    nxt_status[`PST_BIT_AUTHENTICATED_FLAG] = authenticated_flag_ff;
  end

  // read-clear flags: a read that meets a new event keeps the flag set
  always @* begin
    nxt_link_error_flag = pst_flag_next(link_error_evt, sts_rd,
      link_error_flag_ff); // see R1 R2
    nxt_hot_plug_flag = pst_flag_next(hot_plug_evt, sts_rd,
      hot_plug_flag_ff); // see R5 R6
  end

  // approval-clear flags: the host must approve before the engine moves on, except for receiver key ready in repeater mode
  always @* begin
    nxt_key_list_ready = pst_flag_next(key_list_loaded_evt, list_ok,
      key_list_ready_ff); // see R8 R10
    nxt_receiver_key_ready = pst_flag_next(receiver_key_loaded_evt,
      key_ok || auth_fail_evt, receiver_key_ready_ff); // see R11 R13
  end

  // loss, failure and a host restart all drop the authenticated flag
  always @* begin
    nxt_authenticated_flag = pst_flag_next(auth_pass_evt, auth_fail_evt || restart,
      authenticated_flag_ff); // see R14 R16
  end

  // stall comes from the flags before this edge, so it lags them a cycle;
  // the approval strobe itself drops it without waiting for the flag
  always @* begin
    nxt_auth_stall = 1'b0;
    if (key_list_ready_ff && !list_ok)
      nxt_auth_stall = 1'b1; // see R9
    if (receiver_key_ready_ff && !repeater_mode && !key_ok)
      nxt_auth_stall = 1'b1; // see R12
  end

  // read data stands one cycle; writes to the status address do nothing
  always @* begin
    nxt_reg_rdata = 8'h00;
    if (sts_rd)
      nxt_reg_rdata = nxt_status; // see R19
    nxt_restart_auth = restart;
  end

  always @(posedge clk) begin
    if (rst)
      link_error_flag_ff <= 1'b0;
    else
      link_error_flag_ff <= nxt_link_error_flag;
  end

  always @(posedge clk) begin
    if (rst)
      hot_plug_flag_ff <= 1'b0;
    else
      hot_plug_flag_ff <= nxt_hot_plug_flag;
  end

  always @(posedge clk) begin
    if (rst)
      key_list_ready_ff <= 1'b0;
    else
      key_list_ready_ff <= nxt_key_list_ready;
  end

  always @(posedge clk) begin
    if (rst)
      receiver_key_ready_ff <= 1'b0;
    else
      receiver_key_ready_ff <= nxt_receiver_key_ready;
  end

  always @(posedge clk) begin
    if (rst)
      authenticated_flag_ff <= 1'b0;
    else
      authenticated_flag_ff <= nxt_authenticated_flag;
  end

  // every output is a flop of its own so nothing combinational leaves the block
  always @(posedge clk) begin
    if (rst)
      reg_rdata_ff <= 8'h00;
    else
      reg_rdata_ff <= nxt_reg_rdata;
  end

  always @(posedge clk) begin
    if (rst)
      auth_stall_ff <= 1'b0;
    else
      auth_stall_ff <= nxt_auth_stall;
  end

  always @(posedge clk) begin
    if (rst)
      restart_auth_ff <= 1'b0;
    else
      restart_auth_ff <= nxt_restart_auth;
  end

  always @(posedge clk) begin
    if (rst)
      protection_status_ff <= `PST_STATUS_RESET; // see R19
    else
      protection_status_ff <= nxt_status;
  end
endmodule

// ### test/pst_host_model.sv
// host controller model on the register access strobes
`timescale 1ns/1ns
module pst_host_model (
  input wire clk, // system clock
  input wire [7:0] rdata, // read data
  output reg [7:0] addr, // address
  output reg wr, // write strobe
  output reg rd, // read strobe
  output reg [7:0] wdata // write data
);
  initial begin
    {addr, wr, rd, wdata} = 18'h0;
  end
  task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    @(negedge clk);
    {addr, wr, rd, wdata} = {a, w, !w, d};
    @(negedge clk);
    q = rdata;
    // released bus shows inverted address and data with both strobes low, not the last values
    {addr, wr, rd, wdata} = {~a, 2'b00, ~d};
  endtask
endmodule

// ### test/pst_status_reg_chk.sv
// assertion checker for the protection status register
`timescale 1ns/1ns
module pst_status_reg_chk (
  input wire clk, input wire rst, input wire [7:0] reg_addr, input wire reg_wr, // bus
  input wire [7:0] reg_wdata, input wire reg_rd, input wire [7:0] reg_rdata_ff, // bus
  input wire link_error_evt, input wire hot_plug_evt, input wire key_list_loaded_evt, // events
  input wire receiver_key_loaded_evt, input wire auth_pass_evt, input wire auth_fail_evt, // events
  input wire repeater_mode, input wire auth_stall_ff, input wire [7:0] protection_status_ff // mode, out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire rs = reg_rd && reg_addr == 8'hc4;
  wire wc = reg_wr && reg_addr == 8'hc3;
  wire [7:0] ps = protection_status_ff;
  wire lok = wc && reg_wdata[5];
  wire kok = wc && reg_wdata[4];
  property p_err; link_error_evt |-> ##2 ps[7]; endproperty
  a_err: assert property (p_err) else $error("link error not flagged");
  property p_rdclr; rs && !link_error_evt && !hot_plug_evt |-> ##2 !ps[7] && !ps[4]; endproperty
  a_rdclr: assert property (p_rdclr) else $error("read did not clear");
  property p_list; key_list_loaded_evt |-> ##2 ps[2]; endproperty
  a_list: assert property (p_list) else $error("list ready missing");
  property p_lclr; wc && reg_wdata[5] && !key_list_loaded_evt |-> ##2 !ps[2]; endproperty
  a_lclr: assert property (p_lclr) else $error("list ready kept");
  property p_stall; ps[2] && !$past(lok)
    || ps[1] && !$past(repeater_mode) && !$past(kok) |-> auth_stall_ff;
  endproperty
  a_stall: assert property (p_stall) else $error("stall missing");
  property p_kclr; (wc && reg_wdata[4] || auth_fail_evt) && !receiver_key_loaded_evt
    |-> ##2 !ps[1]; endproperty
  a_kclr: assert property (p_kclr) else $error("key ready kept");
  property p_auth; auth_pass_evt |-> ##2 ps[0]; endproperty
  a_auth: assert property (p_auth) else $error("auth not flagged");
  property p_aclr; (auth_fail_evt || wc && reg_wdata[0]) && !auth_pass_evt |-> ##2 !ps[0];
  endproperty
  a_aclr: assert property (p_aclr) else $error("auth kept");
  property p_rdata; rs |=> reg_rdata_ff == ps; endproperty
  a_rdata: assert property (p_rdata) else $error("read data wrong");
  c_rd: cover property (rs && ps[7]);
  c_lst: cover property (wc && reg_wdata[5]);
  c_auth: cover property (auth_pass_evt);
endmodule
bind pst_status_reg pst_status_reg_chk i_pst_status_reg_chk (.clk, .rst, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata_ff, .link_error_evt, .hot_plug_evt, .key_list_loaded_evt,
  .receiver_key_loaded_evt, .auth_pass_evt, .auth_fail_evt, .repeater_mode, .auth_stall_ff,
  .protection_status_ff);

// ### test/pst_status_reg_tb.sv
// self-checking bench for the protection status register
`timescale 1ns/1ns
module pst_status_reg_tb;
  reg clk = 0, rst = 1, rpt = 0, irq_n = 1, lock = 0, pres = 0;
  reg [5:0] ev = 6'h00;
  reg [7:0] q;
  wire [7:0] addr, wd, rdata, ps;
  wire wr, rd, stall, rs;
  integer err_total = 0, cmp_count = 0, cyc = 0;
  initial forever #50 clk = ~clk;
  pst_host_model i_pst_host_model (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wd));
  pst_status_reg i_pst_status_reg (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wd), .reg_rd(rd), .reg_rdata_ff(rdata), .link_error_evt(ev[5]),
    .hot_plug_evt(ev[4]), .key_list_loaded_evt(ev[3]), .receiver_key_loaded_evt(ev[2]),
    .auth_pass_evt(ev[1]), .auth_fail_evt(ev[0]), .repeater_mode(rpt),
    .remote_irq_input(irq_n), .remote_lock_pin(lock), .receiver_present_pin(pres),
    .auth_stall_ff(stall), .restart_auth_ff(rs), .protection_status_ff(ps));
  task chk(input [7:0] got, input [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rc(input [7:0] a, input [7:0] e);
    i_pst_host_model.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task wc(input [7:0] d);
    i_pst_host_model.xfer(1'b1, 8'hc3, d, q);
  endtask
  task pulse(input [5:0] m);
    @(negedge clk);
    ev = m;
    @(negedge clk);
    ev = 6'h00;
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 500) begin
      err_total = err_total + 1;
      stop_test;
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    chk(ps, 8'h00);
    {rst, irq_n, lock, pres} = 4'b0011;
    i_pst_host_model.xfer(1'b1, 8'hc4, 8'hff, q);
    repeat (4) @(negedge clk);
    rc(8'hc4, 8'h28);
    rc(8'h55, 8'h00);
    $display("test pins done");
    pulse(6'h30);
    rc(8'hc4, 8'hb8);
    rc(8'hc4, 8'h28);
    $display("test read clear done");
    pulse(6'h08);
    rc(8'hc4, 8'h2c);
    chk({7'h00, stall}, 8'h01);
    wc(8'h20);
    rc(8'hc4, 8'h28);
    chk({7'h00, stall}, 8'h00);
    pulse(6'h04);
    rc(8'hc4, 8'h2a);
    chk({7'h00, stall}, 8'h01);
    wc(8'h10);
    rc(8'hc4, 8'h28);
    rpt = 1;
    pulse(6'h04);
    rc(8'hc4, 8'h2a);
    chk({7'h00, stall}, 8'h00);
    pulse(6'h01);
    rc(8'hc4, 8'h28);
    $display("test keys done");
    pulse(6'h02);
    rc(8'hc4, 8'h29);
    wc(8'h01);
    chk({7'h00, rs}, 8'h01);
    rc(8'hc4, 8'h28);
    pulse(6'h02);
    pulse(6'h01);
    rc(8'hc4, 8'h28);
    $display("test auth done");
    stop_test;
  end
endmodule
